// >>> common/padc_pkg.sv
/*
 * Shared constants and carriers for the potentiometer address decode and
 * control register block.
 * Assumes a 16-bit serial frame: 4-bit opcode, 4-bit address, 8-bit data.
 */
package padc_pkg;

    // ==========================================================
    // Widths and counts
    localparam int CHANNELS = 4;
    localparam int CODE_W = 8;
    localparam int TAPS = 256;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;

    // ==========================================================
    // Opcodes
    localparam logic [3:0] OP_WRITE_WIPER = 4'h1;
    localparam logic [3:0] OP_WRITE_INPUT = 4'h2;
    localparam logic [3:0] OP_READBACK = 4'h3;
    localparam logic [3:0] OP_COPY_INPUT = 4'h6;
    localparam logic [3:0] OP_NVM_COPY = 4'h7;
    localparam logic [3:0] OP_WRITE_NVM = 4'h8;
    localparam logic [3:0] OP_SW_RESET = 4'hb;
    localparam logic [3:0] OP_CTRL_WRITE = 4'hd;

    // ==========================================================
    // Readback selectors
    localparam logic [1:0] RB_INPUT = 2'h0;
    localparam logic [1:0] RB_NVM = 2'h1;
    localparam logic [1:0] RB_CTRL = 2'h2;
    localparam logic [1:0] RB_WIPER = 2'h3;

    // ==========================================================
    // Control register fields and reset values
    localparam int WP_POS = 0;
    localparam int NVM_EN_POS = 1;
    localparam int GAIN_POS = 2;
    localparam int BURST_POS = 3;
    localparam logic [3:0] CTRL_RESET = 4'h3;
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [7:0] NVM_RESET = 8'h80;

    typedef struct packed {
        logic burstEnableBit;
        logic gainModeBit;
        logic nvmProgramEnableBit;
        logic writeProtectBit;
    } padc_ctrl_t;

    typedef struct packed {
        logic [3:0] opcode;
        logic broadcastSelectBit;
        logic sideSelectBit;
        logic channelSelectHigh;
        logic channelSelectLow;
        logic [7:0] data;
    } padc_cmd_t;

endpackage

// >>> verilog/padc_top.sv
/*
 * Serial command front end, channel address decode, control register and
 * per-channel wiper, input and stored-code registers of a quad potentiometer.
 * Assumes the host drives sclk, syncN and sdi from another clock domain; all
 * three are synchronised to sys_clk, so sclk must be well below sys_clk / 4.
 */
// Function
// R1: An address with the top bit set hits every channel, but stored-memory commands ignore it.
// R2: Top two address bits low pick channel by the low two bits, the B side in either mode.
// R3: Second address bit set picks the A-side registers, only in gain mode, never for memory. Readback picks the A-side registers in either mode.
// R4: Write protect low freezes the wiper at the stored code, high lets writes through.
// R5: Program enable low refuses stored-memory programming, high permits it.
// R6: Gain mode bit low selects potentiometer mode, high linear gain mode.
// R7: Burst bit enables burst mode, which then survives stop and repeated start.
// R8: Each wiper holds an 8-bit code decoded to exactly one tap.
// R9: In potentiometer mode the A-side setting is the complement of the wiper code.
// R10: In gain mode the A-side setting follows its own register, not the B code.
// R11: A control write loads four data bits; readback with selector 10 returns them.
// R12: Reset and software reset restore the control defaults.
`timescale 1ns/100ps
module padc_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic syncN,
    input wire logic sdi,
    output logic sdo,
    output logic burstMode,
    output logic [7:0] wiperToB [4],
    output logic [7:0] wiperToA [4],
    output logic [255:0] tapSelect [4]
);

    // ==========================================================
    // Input synchronisers and edge detect
    logic [2:0] sclkSync_r, syncSync_r, sdiSync_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclkSync_r <= 3'h0;
            syncSync_r <= 3'h7;
            sdiSync_r <= 3'h0;
        end else begin
            sclkSync_r <= {sclkSync_r[1:0], sclk};
            syncSync_r <= {syncSync_r[1:0], syncN};
            sdiSync_r <= {sdiSync_r[1:0], sdi};
        end
    end

    logic sclkRise, sclkFall, frameOpen, frameEnd, frameStart;
    assign sclkRise = sclkSync_r[1] & ~sclkSync_r[2];
    assign sclkFall = ~sclkSync_r[1] & sclkSync_r[2];
    assign frameOpen = ~syncSync_r[1];
    assign frameEnd = syncSync_r[1] & ~syncSync_r[2];
    assign frameStart = ~syncSync_r[1] & syncSync_r[2];

    // ==========================================================
    // Frame shift-in
    logic [15:0] shiftIn_r;
    logic [4:0] bitCnt_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shiftIn_r <= 16'h0000;
            bitCnt_r <= 5'h00;
        end else if (frameStart) begin
            bitCnt_r <= 5'h00;
        end else if (frameOpen && sclkRise) begin
            shiftIn_r <= {shiftIn_r[14:0], sdiSync_r[1]};
            if (bitCnt_r != 5'h1f) begin
                bitCnt_r <= bitCnt_r + 5'h01;
            end
        end
    end

    // Short or long frames are dropped rather than half executed
    logic exec;
    padc_pkg::padc_cmd_t cmd;
    assign exec = frameEnd && (bitCnt_r == padc_pkg::FRAME_LEN);
    assign cmd = shiftIn_r;

    // ==========================================================
    // Control register
    padc_pkg::padc_ctrl_t ctrl_r;
    logic swReset;
    assign swReset = exec && (cmd.opcode == padc_pkg::OP_SW_RESET);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= padc_pkg::CTRL_RESET; // see R12
        end else if (swReset) begin
            ctrl_r <= padc_pkg::CTRL_RESET; // see R12
        end else if (exec && cmd.opcode == padc_pkg::OP_CTRL_WRITE) begin
            ctrl_r <= cmd.data[3:0]; // see R11
        end
    end

    property p_ctrl_load;
        @(posedge sys_clk) disable iff (!resetn)
        exec && cmd.opcode == padc_pkg::OP_CTRL_WRITE |=> ctrl_r == $past(cmd.data[3:0]);
    endproperty
    a_ctrl_load: assert property (p_ctrl_load) // see R11
        else $error("Control write did not load four data bits");

    property p_sw_reset;
        @(posedge sys_clk) disable iff (!resetn)
        swReset |=> ctrl_r == padc_pkg::CTRL_RESET;
    endproperty
    a_sw_reset: assert property (p_sw_reset) // see R12
        else $error("Software reset did not restore control defaults");

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            burstMode <= 1'b0;
        end else begin
            burstMode <= ctrl_r.burstEnableBit; // see R7
        end
    end

    property p_burst;
        @(posedge sys_clk) disable iff (!resetn)
        burstMode == $past(ctrl_r.burstEnableBit);
    endproperty
    a_burst: assert property (p_burst) // see R7
        else $error("Burst output does not follow its control bit");

    // ==========================================================
    // Per-channel registers
    logic [7:0] wipB_r [4];
    logic [7:0] inB_r [4];
    logic [7:0] wipA_r [4];
    logic [7:0] inA_r [4];
    logic [7:0] nvm_r [4];

    genvar g;
    generate
        for (g = 0; g < padc_pkg::CHANNELS; g++) begin : gChan
            logic chanMatch, hitB, hitA, hitMem;
            assign chanMatch = {cmd.channelSelectHigh, cmd.channelSelectLow} == 2'(g);
            // see R1, R2
            assign hitB = exec && (cmd.broadcastSelectBit || (!cmd.sideSelectBit && chanMatch));
            // see R3
            assign hitA = exec && ctrl_r.gainModeBit &&
                (cmd.broadcastSelectBit || (cmd.sideSelectBit && chanMatch));
            // see R1, R3
            assign hitMem = exec && !cmd.broadcastSelectBit && !cmd.sideSelectBit && chanMatch;

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    wipB_r[g] <= padc_pkg::WIPER_RESET;
                end else if (swReset || !ctrl_r.writeProtectBit) begin
                    wipB_r[g] <= nvm_r[g]; // see R4
                end else if (hitB && cmd.opcode == padc_pkg::OP_WRITE_WIPER) begin
                    wipB_r[g] <= cmd.data;
                end else if (hitB && cmd.opcode == padc_pkg::OP_COPY_INPUT) begin
                    wipB_r[g] <= inB_r[g];
                end else if (hitMem && cmd.opcode == padc_pkg::OP_NVM_COPY && !cmd.data[0]) begin
                    wipB_r[g] <= nvm_r[g];
                end
            end

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    inB_r[g] <= padc_pkg::WIPER_RESET;
                end else if (hitB && cmd.opcode == padc_pkg::OP_WRITE_INPUT) begin
                    inB_r[g] <= cmd.data;
                end
            end

            // The A side has no stored code, so write protect simply holds it
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    wipA_r[g] <= padc_pkg::WIPER_RESET;
                    inA_r[g] <= padc_pkg::WIPER_RESET;
                end else begin
                    if (hitA && cmd.opcode == padc_pkg::OP_WRITE_INPUT) begin
                        inA_r[g] <= cmd.data;
                    end
                    if (ctrl_r.writeProtectBit && hitA) begin
                        if (cmd.opcode == padc_pkg::OP_WRITE_WIPER) begin
                            wipA_r[g] <= cmd.data;
                        end else if (cmd.opcode == padc_pkg::OP_COPY_INPUT) begin
                            wipA_r[g] <= inA_r[g];
                        end
                    end
                end
            end

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    nvm_r[g] <= padc_pkg::NVM_RESET;
                end else if (hitMem && ctrl_r.nvmProgramEnableBit) begin // see R5
                    if (cmd.opcode == padc_pkg::OP_WRITE_NVM) begin
                        nvm_r[g] <= cmd.data;
                    end else if (cmd.opcode == padc_pkg::OP_NVM_COPY && cmd.data[0]) begin
                        nvm_r[g] <= wipB_r[g];
                    end
                end
            end

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    wiperToB[g] <= padc_pkg::WIPER_RESET;
                    wiperToA[g] <= ~padc_pkg::WIPER_RESET;
                    // Reset shows the decoded reset code, so one tap is always on
                    tapSelect[g] <= 256'h1 << padc_pkg::WIPER_RESET;
                end else begin
                    wiperToB[g] <= wipB_r[g];
                    // see R6, R9, R10
                    wiperToA[g] <= ctrl_r.gainModeBit ? wipA_r[g] : ~wipB_r[g];
                    tapSelect[g] <= 256'h1 << wipB_r[g]; // see R8
                end
            end

            property p_pot_a;
                @(posedge sys_clk) disable iff (!resetn)
                !$past(ctrl_r.gainModeBit) |-> wiperToA[g] == ~$past(wipB_r[g]);
            endproperty
            a_pot_a: assert property (p_pot_a) // see R9
                else $error("A side not complement of wiper");

            property p_gain_a;
                @(posedge sys_clk) disable iff (!resetn)
                $past(ctrl_r.gainModeBit) |-> wiperToA[g] == $past(wipA_r[g]);
            endproperty
            a_gain_a: assert property (p_gain_a) // see R10
                else $error("A side does not follow its own register");

            property p_tap_sel;
                @(posedge sys_clk) disable iff (!resetn)
                $onehot(tapSelect[g]) && tapSelect[g][$past(wipB_r[g])];
            endproperty
            a_tap_sel: assert property (p_tap_sel) // see R8
                else $error("Tap select is not the single decoded code");

            property p_freeze;
                @(posedge sys_clk) disable iff (!resetn)
                !ctrl_r.writeProtectBit |=> wipB_r[g] == $past(nvm_r[g]);
            endproperty
            a_freeze: assert property (p_freeze) // see R4
                else $error("Protected wiper left the stored code");

            property p_nvm_refuse;
                @(posedge sys_clk) disable iff (!resetn)
                !ctrl_r.nvmProgramEnableBit |=> $stable(nvm_r[g]);
            endproperty
            a_nvm_refuse: assert property (p_nvm_refuse) // see R5
                else $error("Stored code changed with programming disabled");

            property p_bcast_mem;
                @(posedge sys_clk) disable iff (!resetn)
                exec && cmd.broadcastSelectBit |=> $stable(nvm_r[g]);
            endproperty
            a_bcast_mem: assert property (p_bcast_mem) // see R1
                else $error("Stored code took a broadcast command");
        end
    endgenerate

    // ==========================================================
    // Readback
    logic [7:0] rbValue;
    logic [1:0] rbChan;
    assign rbChan = {cmd.channelSelectHigh, cmd.channelSelectLow};

    always_comb begin
        case (cmd.data[1:0])
            padc_pkg::RB_INPUT: rbValue = cmd.sideSelectBit ? inA_r[rbChan] : inB_r[rbChan];
            padc_pkg::RB_NVM: rbValue = nvm_r[rbChan];
            padc_pkg::RB_CTRL: rbValue = {4'h0, ctrl_r}; // see R11
            padc_pkg::RB_WIPER: rbValue = cmd.sideSelectBit ? wipA_r[rbChan] : wipB_r[rbChan];
            default: rbValue = 8'h00;
        endcase
    end

    // Answer shifts out during the next frame, changing on falling sclk
    logic [15:0] shiftOut_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shiftOut_r <= 16'h0000;
        end else if (exec) begin
            shiftOut_r <= (cmd.opcode == padc_pkg::OP_READBACK) ? {8'h00, rbValue} : 16'h0000;
        end else if (frameOpen && sclkFall) begin
            shiftOut_r <= {shiftOut_r[14:0], 1'b0};
        end
    end

    assign sdo = shiftOut_r[15];

endmodule

// >>> tb/padc_host_model.sv
/*
 * Host controller model that sends 16-bit serial frames to the block.
 * Assumes the device takes sdi on rising sclk and moves sdo on falling sclk;
 * sdi is set up half a bit ahead, and sclk stands low outside frames.
 */
`timescale 1ns/100ps
module padc_host_model (
    input wire logic sysClk,
    output logic sclk,
    output logic syncN,
    output logic sdi,
    input wire logic sdo
);
    // ==========================================================
    // Idle levels
    initial begin
        sclk = 1'b0;
        syncN = 1'b1;
        sdi = 1'b0;
    end

    // Half of the 800 ns link period is four system clocks
    task automatic halfBit();
        repeat (4) @(posedge sysClk);
    endtask

    // ==========================================================
    // One whole frame, MSB first; sdo is shifted in at the same time
    task automatic frame(input logic [15:0] word, output logic [15:0] rdata);
        rdata = 16'h0;
        @(posedge sysClk);
        syncN <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi <= word[i];
            halfBit();
            sclk <= 1'b1;
            halfBit();
            rdata = {rdata[14:0], sdo};
            sclk <= 1'b0;
        end
        halfBit();
        syncN <= 1'b1;
        // Released data line must not keep showing the last bit
        sdi <= ~word[0];
        halfBit();
        halfBit();
    endtask
endmodule

// >>> tb/padc_top_tb.sv
/*
 * Self-checking bench: frames from the host model, checks on wiper outputs
 * and readback. Assumes readback data returns in the low byte of the next frame.
 */
`timescale 1ns/100ps
module padc_top_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, syncN, sdi, sdo, burstMode;
    logic [7:0] wiperToB [4];
    logic [7:0] wiperToA [4];
    logic [255:0] tapSelect [4];
    logic [15:0] rd;
    int nMismatch = 0;
    int checksDone = 0;

    padc_host_model host (.sysClk(sys_clk), .sclk(sclk), .syncN(syncN), .sdi(sdi), .sdo(sdo));
    padc_top uut (.sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .syncN(syncN), .sdi(sdi),
        .sdo(sdo), .burstMode(burstMode), .wiperToB(wiperToB), .wiperToA(wiperToA),
        .tapSelect(tapSelect));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Reporting
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nMismatch++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // ==========================================================
    // Access tasks
    task automatic send(input logic [3:0] op, input logic [3:0] addr, input logic [7:0] data);
        host.frame({op, addr, data}, rd);
        repeat (20) @(posedge sys_clk);
    endtask

    task automatic readBack(input logic [3:0] addr, input logic [1:0] sel, input logic [7:0] exp);
        send(padc_pkg::OP_READBACK, addr, {6'h0, sel});
        host.frame(16'h0, rd);
        check({8'h0, rd[7:0]}, {8'h0, exp});
    endtask

    // B code, A setting and one-hot tap of one channel
    task automatic chan(input int i, input logic [7:0] b, input logic [7:0] a);
        check({8'h0, wiperToB[i]}, {8'h0, b});
        check({8'h0, wiperToA[i]}, {8'h0, a});
        check({15'h0, tapSelect[i] === (256'h1 << b)}, 16'h1);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) chan(i, 8'h80, 8'h7f);
        check({15'h0, burstMode}, 16'h0);
        readBack(4'h0, padc_pkg::RB_CTRL, 8'h03);
        // Single channel, then every channel at once
        send(padc_pkg::OP_WRITE_WIPER, 4'h2, 8'h35);
        chan(2, 8'h35, 8'hca);
        chan(1, 8'h80, 8'h7f);
        send(padc_pkg::OP_WRITE_WIPER, 4'hb, 8'h5a);
        for (int i = 0; i < 4; i++) chan(i, 8'h5a, 8'ha5);
        // A side is meaningless in potentiometer mode
        send(padc_pkg::OP_WRITE_WIPER, 4'h4, 8'h11);
        chan(0, 8'h5a, 8'ha5);
        // Gain mode: A side has its own register
        send(padc_pkg::OP_CTRL_WRITE, 4'h0, 8'h07);
        readBack(4'h0, padc_pkg::RB_CTRL, 8'h07);
        send(padc_pkg::OP_WRITE_WIPER, 4'h5, 8'h22);
        check({8'h0, wiperToA[1]}, 16'h0022);
        check({8'h0, wiperToB[1]}, 16'h005a);
        // Write protect low freezes the wiper
        send(padc_pkg::OP_CTRL_WRITE, 4'h0, 8'h06);
        send(padc_pkg::OP_WRITE_WIPER, 4'h0, 8'h99);
        check({8'h0, wiperToB[0]}, {8'h0, padc_pkg::NVM_RESET});
        // Program enable gates stored-memory writes
        send(padc_pkg::OP_CTRL_WRITE, 4'h0, 8'h05);
        send(padc_pkg::OP_WRITE_NVM, 4'h0, 8'h44);
        readBack(4'h0, padc_pkg::RB_NVM, padc_pkg::NVM_RESET);
        send(padc_pkg::OP_CTRL_WRITE, 4'h0, 8'h07);
        send(padc_pkg::OP_WRITE_NVM, 4'h0, 8'h44);
        readBack(4'h0, padc_pkg::RB_NVM, 8'h44);
        // Broadcast address is refused by stored memory
        send(padc_pkg::OP_WRITE_NVM, 4'h8, 8'h66);
        readBack(4'h0, padc_pkg::RB_NVM, 8'h44);
        // Burst mode, then software reset restores defaults
        send(padc_pkg::OP_CTRL_WRITE, 4'h0, 8'h0f);
        check({15'h0, burstMode}, 16'h1);
        send(padc_pkg::OP_SW_RESET, 4'h0, 8'h00);
        check({15'h0, burstMode}, 16'h0);
        readBack(4'h0, padc_pkg::RB_CTRL, padc_pkg::CTRL_RESET);
        // Input register, copy to wiper, then wiper into stored memory
        send(padc_pkg::OP_WRITE_INPUT, 4'h3, 8'h3c);
        readBack(4'h3, padc_pkg::RB_INPUT, 8'h3c);
        chan(3, 8'h80, 8'h7f);
        send(padc_pkg::OP_COPY_INPUT, 4'h3, 8'h00);
        chan(3, 8'h3c, 8'hc3);
        readBack(4'h3, padc_pkg::RB_WIPER, 8'h3c);
        send(padc_pkg::OP_NVM_COPY, 4'h3, 8'h01);
        readBack(4'h3, padc_pkg::RB_NVM, 8'h3c);
        print_verdict();
    end

    // Cuts a hang short
    initial begin
        repeat (100000) @(posedge sys_clk);
        nMismatch++;
        $display("ERROR at %0t: run limit reached", $time);
        print_verdict();
    end
endmodule
